// ===== src/sdram_ctl_pkg.sv
// Purpose: Constants and carrier types for the SDRAM control and refresh timer.
// Assumes: 32-bit register port, one system clock at 25 MHz.
// Notes:   Offsets of the register word indices are local choices.
package sdram_ctl_pkg;

   // ==========================================================
   // Register map
   localparam logic [3:0] ADDR_CONTROL   = 4'h0;
   localparam logic [3:0] ADDR_TIMING    = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT  = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK  = 4'hc;

   // ==========================================================
   // Control register fields
   localparam int BIT_COL_WIDTH   = 26;
   localparam int BIT_REFRESH_EN  = 25;
   localparam int BIT_INIT        = 24;
   localparam int POS_RCD         = 20;
   localparam int POS_RP          = 16;
   localparam int POS_RC          = 12;
   localparam logic       RST_COL_WIDTH  = 1'b0;
   localparam logic       RST_REFRESH_EN = 1'b1;
   localparam logic [3:0] RST_RCD        = 4'h8;
   localparam logic [3:0] RST_RP         = 4'h8;
   localparam logic [3:0] RST_RC         = 4'hf;

   // ==========================================================
   // Timing register fields
   localparam int POS_COUNT  = 12;
   localparam int POS_PERIOD = 0;
   localparam logic [11:0] RST_PERIOD = 12'h080;
   localparam logic [11:0] RST_COUNT  = 12'h080;

   // ==========================================================
   // Column address widths
   localparam logic [3:0]  COL_PINS_WIDE   = 4'h9;
   localparam logic [3:0]  COL_PINS_NARROW = 4'h8;
   localparam logic [9:0]  ROW_ELEMS_WIDE   = 10'h200;
   localparam logic [9:0]  ROW_ELEMS_NARROW = 10'h100;

   // ==========================================================
   // Interrupt status bits
   localparam int IRQ_REFRESH = 0;
   localparam int IRQ_INIT    = 1;

   // ==========================================================
   // Rate: one EMIF cycle is one half-rate clock period (two clk).
   localparam int CLK_DIV = 2;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic [3:0] row_to_column_delay;
      logic [3:0] precharge_period;
      logic [3:0] row_cycle_period;
   } sdram_timing_t;

endpackage

// ===== src/sdram_control_refresh_timer.sv
// Purpose: SDRAM control register, refresh timing register and the
//          reloading refresh countdown with its event and interrupt.
// Assumes: Register port with one-cycle strobes; read data one cycle later.
// Notes:   The countdown also serves as a general purpose periodic timer.
//
// Functional notes
// - Column width select 0 drives nine column pins, 512 elements per row.
// - Column width select 1 drives eight column pins, 256 elements per row.
// - Refresh enable 1 lets refresh requests out; 0 blocks them.
// - Writing 1 to the init bit starts SDRAM init; writing 0 does nothing.
// - The init bit reads back an undefined value; do not rely on it.
// - Row-to-column field holds delay cycles minus one; wait value plus one.
// - Precharge field holds precharge cycles minus one; honour value plus one.
// - Row cycle field holds cycles minus one; space activations value plus one.
// - Reserved bits of both SDRAM registers read zero and ignore writes.
// - Period field sets the refresh interval in EMIF cycles; resets to 080h.
// - At zero the countdown reloads from period and raises the refresh event.
// - Timing bits 23-12 read the live countdown; read only, reset 080h.
// - Refresh event goes to the DMA controller and to the CPU interrupt.
// - Countdown and event stay usable as a timer without SDRAM.
// - One EMIF cycle equals one period of the half-rate clock output.
// - Settings apply to all SDRAM spaces; do not change them mid-access.
`timescale 1ns/100ps
`default_nettype none

module sdram_control_refresh_timer (
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   input  wire logic [3:0]                  reg_addr,
   input  wire logic [31:0]                 reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output var  logic [31:0]                 reg_rdata,
   output var  logic                        half_rate_clock_out,
   output var  logic                        column_width_select,
   output var  logic [3:0]                  column_pin_count,
   output var  logic [9:0]                  row_elements,
   output var  sdram_ctl_pkg::sdram_timing_t timing_fields,
   output var  logic [4:0]                  rcd_wait_cycles,
   output var  logic [4:0]                  rp_wait_cycles,
   output var  logic [4:0]                  rc_wait_cycles,
   output var  logic                        init_start,
   output var  logic                        bus_request_out,
   input  wire logic                        refresh_done,
   output var  logic                        refresh_event,
   output var  logic                        dma_sync_event,
   output var  logic                        irq
);
   import sdram_ctl_pkg::*;

   // ==========================================================
   // Register port decode
   reg_req_t req;
   always_comb begin
      req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   end

   function automatic logic [4:0] plus_one(input logic [3:0] v);
      plus_one = {1'b0, v} + 5'h01;
   endfunction

   // ==========================================================
   // Control register state
   logic          col_wide_reg,   col_wide_next;
   logic          refresh_en_reg, refresh_en_next;
   sdram_timing_t tim_reg,        tim_next;
   logic          init_reg,       init_next;

   always_comb begin
      col_wide_next   = col_wide_reg;
      refresh_en_next = refresh_en_reg;
      tim_next        = tim_reg;
      init_next       = 1'b0;
      // Only fields that exist are stored; reserved bits are dropped.
      if (req.wr && req.addr == ADDR_CONTROL) begin
         col_wide_next   = req.wdata[BIT_COL_WIDTH];
         refresh_en_next = req.wdata[BIT_REFRESH_EN];
         init_next       = req.wdata[BIT_INIT];
         tim_next.row_to_column_delay = req.wdata[POS_RCD +: 4];
         tim_next.precharge_period    = req.wdata[POS_RP +: 4];
         tim_next.row_cycle_period    = req.wdata[POS_RC +: 4];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         col_wide_reg   <= RST_COL_WIDTH;
         refresh_en_reg <= RST_REFRESH_EN;
         tim_reg        <= '{RST_RCD, RST_RP, RST_RC};
         init_reg       <= 1'b0;
      end else begin
         col_wide_reg   <= col_wide_next;
         refresh_en_reg <= refresh_en_next;
         tim_reg        <= tim_next;
         init_reg       <= init_next;
      end
   end

   // ==========================================================
   // EMIF cycle divider: one enable every second clk.
   logic div_reg, div_next;
   logic emif_tick;
   always_comb begin
      div_next  = ~div_reg;
      emif_tick = div_reg;
   end

   // ==========================================================
   // Refresh countdown
   logic [11:0] period_reg, period_next;
   logic [11:0] count_reg,  count_next;
   logic        expire;
   always_comb begin
      period_next = period_reg;
      if (req.wr && req.addr == ADDR_TIMING) begin
         period_next = req.wdata[POS_PERIOD +: 12];
      end
      count_next = count_reg;
      expire     = 1'b0;
      // The timer runs whether or not refresh is on, so it doubles as a
      // general purpose timer.
      if (emif_tick) begin
         if (count_reg == 12'h000) begin
            count_next = period_reg;
            expire     = 1'b1;
         end else begin
            count_next = count_reg - 12'h001;
         end
      end
   end

   // ==========================================================
   // Refresh request to the bus: pending until the sequencer answers.
   logic bus_request_out_next;
   always_comb begin
      bus_request_out_next = bus_request_out;
      if (refresh_done) begin
         bus_request_out_next = 1'b0;
      end
      if (expire && refresh_en_reg) begin
         bus_request_out_next = 1'b1;
      end
      if (!refresh_en_reg) begin
         bus_request_out_next = 1'b0;
      end
   end

   // ==========================================================
   // Interrupt status and mask. A read of status clears it, but an
   // event in the same cycle is kept.
   logic [1:0] stat_reg, stat_next;
   logic [1:0] mask_reg, mask_next;
   always_comb begin
      stat_next = stat_reg;
      mask_next = mask_reg;
      if (req.rd && req.addr == ADDR_IRQ_STAT) begin
         stat_next = 2'b00;
      end
      if (expire) begin
         stat_next[IRQ_REFRESH] = 1'b1;
      end
      if (init_reg) begin
         stat_next[IRQ_INIT] = 1'b1;
      end
      if (req.wr && req.addr == ADDR_IRQ_MASK) begin
         mask_next = req.wdata[1:0];
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   logic [31:0] rdata_next;
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (req.rd) begin
         unique case (req.addr)
            ADDR_CONTROL: begin
               // The init bit has no storage and reads as zero.
               rdata_next[BIT_COL_WIDTH]   = col_wide_reg;
               rdata_next[BIT_REFRESH_EN]  = refresh_en_reg;
               rdata_next[POS_RCD +: 4]    = tim_reg.row_to_column_delay;
               rdata_next[POS_RP +: 4]     = tim_reg.precharge_period;
               rdata_next[POS_RC +: 4]     = tim_reg.row_cycle_period;
            end
            ADDR_TIMING: begin
               rdata_next[POS_COUNT +: 12]  = count_reg;
               rdata_next[POS_PERIOD +: 12] = period_reg;
            end
            ADDR_IRQ_STAT: rdata_next[1:0] = stat_reg;
            ADDR_IRQ_MASK: rdata_next[1:0] = mask_reg;
            default:       rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Registered outputs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div_reg             <= 1'b0;
         period_reg          <= RST_PERIOD;
         count_reg           <= RST_COUNT;
         stat_reg            <= 2'b00;
         mask_reg            <= 2'b00;
         reg_rdata           <= 32'h0000_0000;
         half_rate_clock_out <= 1'b0;
         bus_request_out     <= 1'b0;
         refresh_event       <= 1'b0;
         dma_sync_event      <= 1'b0;
         irq                 <= 1'b0;
      end else begin
         div_reg             <= div_next;
         period_reg          <= period_next;
         count_reg           <= count_next;
         stat_reg            <= stat_next;
         mask_reg            <= mask_next;
         reg_rdata           <= rdata_next;
         half_rate_clock_out <= div_next;
         bus_request_out     <= bus_request_out_next;
         refresh_event       <= expire;
         dma_sync_event      <= expire;
         irq                 <= |(stat_next & mask_next);
      end
   end

   // ==========================================================
   // SDRAM-side settings
   // They are taken from the next control values, so the pins follow a
   // write one cycle later; changing them mid-access is the software's
   // risk, as the sequencer sees the new values at once.
   logic [3:0] pins_next;
   logic [9:0] rows_next;
   logic [4:0] rcd_next;
   logic [4:0] rp_next;
   logic [4:0] rc_next;
   always_comb begin
      if (col_wide_next) begin
         pins_next = COL_PINS_NARROW;
         rows_next = ROW_ELEMS_NARROW;
      end else begin
         pins_next = COL_PINS_WIDE;
         rows_next = ROW_ELEMS_WIDE;
      end
      rcd_next = plus_one(tim_next.row_to_column_delay);
      rp_next  = plus_one(tim_next.precharge_period);
      rc_next  = plus_one(tim_next.row_cycle_period);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         column_width_select <= RST_COL_WIDTH;
         column_pin_count    <= COL_PINS_WIDE;
         row_elements        <= ROW_ELEMS_WIDE;
         timing_fields       <= '{RST_RCD, RST_RP, RST_RC};
         rcd_wait_cycles     <= plus_one(RST_RCD);
         rp_wait_cycles      <= plus_one(RST_RP);
         rc_wait_cycles      <= plus_one(RST_RC);
         init_start          <= 1'b0;
      end else begin
         column_width_select <= col_wide_next;
         column_pin_count    <= pins_next;
         row_elements        <= rows_next;
         timing_fields       <= tim_next;
         rcd_wait_cycles     <= rcd_next;
         rp_wait_cycles      <= rp_next;
         rc_wait_cycles      <= rc_next;
         init_start          <= init_next;
      end
   end

endmodule // sdram_control_refresh_timer

`default_nettype wire

// ===== tb/sdram_refresh_partner.sv
// Purpose: Refresh sequencer stand-in that answers bus requests.
// Assumes: Same clock as the block; slow selects the long answer.
// Notes:   Gives one done pulse per request.
`timescale 1ns/100ps
`default_nettype none
module sdram_refresh_partner (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic bus_request_out,
   input  wire logic slow,
   output var  logic refresh_done
);
   logic [3:0] wait_reg;
   // Saturating, so a stuck request never gets a second pulse.
   always_ff @(posedge clk) begin
      if (sys_rst || !bus_request_out) begin
         wait_reg     <= 4'h0;
         refresh_done <= 1'b0;
      end else begin
         wait_reg     <= wait_reg + {3'h0, wait_reg != 4'hf};
         refresh_done <= wait_reg == (slow ? 4'h9 : 4'h1);
      end
   end
endmodule // sdram_refresh_partner
`default_nettype wire

// ===== tb/sdram_refresh_asserts.sv
// Purpose: Port checks for the SDRAM control and refresh timer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound from the bench top file.
`timescale 1ns/100ps
`default_nettype none
module sdram_refresh_asserts (
   input wire logic                         clk,
   input wire logic                         sys_rst,
   input wire logic [3:0]                   reg_addr,
   input wire logic [31:0]                  reg_wdata,
   input wire logic                         reg_wr,
   input wire logic                         reg_rd,
   input wire logic [31:0]                  reg_rdata,
   input wire logic                         half_rate_clock_out,
   input wire logic                         column_width_select,
   input wire logic [3:0]                   column_pin_count,
   input wire logic [9:0]                   row_elements,
   input wire sdram_ctl_pkg::sdram_timing_t timing_fields,
   input wire logic [4:0]                   rcd_wait_cycles,
   input wire logic [4:0]                   rp_wait_cycles,
   input wire logic [4:0]                   rc_wait_cycles,
   input wire logic                         init_start,
   input wire logic                         bus_request_out,
   input wire logic                         refresh_done,
   input wire logic                         refresh_event,
   input wire logic                         dma_sync_event
);
   import sdram_ctl_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Assertions
   col_pins_a: assert property (
      column_pin_count == (column_width_select ? 4'h8 : 4'h9)
      && row_elements == (column_width_select ? 10'h100 : 10'h200))
      else $error("column geometry wrong");
   rcd_wait_a: assert property (
      rcd_wait_cycles == timing_fields.row_to_column_delay + 5'h1)
      else $error("rcd wait wrong");
   rp_wait_a: assert property (
      rp_wait_cycles == timing_fields.precharge_period + 5'h1)
      else $error("rp wait wrong");
   rc_wait_a: assert property (
      rc_wait_cycles == timing_fields.row_cycle_period + 5'h1)
      else $error("rc wait wrong");
   event_pair_a: assert property (
      refresh_event == dma_sync_event) else $error("events differ");
   event_pulse_a: assert property (
      refresh_event |=> !refresh_event) else $error("event too long");
   req_clear_a: assert property (
      bus_request_out && refresh_done |=> !bus_request_out)
      else $error("request not cleared");
   rsvd_read_a: assert property (
      $past(reg_rd) && $past(reg_addr) == ADDR_CONTROL
      |-> reg_rdata[31:27] == 5'h0 && reg_rdata[11:0] == 12'h0)
      else $error("reserved bits set");
   half_clk_a: assert property (
      !$past(sys_rst) |-> half_rate_clock_out != $past(half_rate_clock_out))
      else $error("half clock stuck");
   init_pulse_a: assert property (
      init_start == ($past(reg_wr) && $past(reg_addr) == ADDR_CONTROL
                     && $past(reg_wdata[BIT_INIT])))
      else $error("init pulse wrong");
   cover property (refresh_event);
   cover property (bus_request_out && refresh_done);
   cover property (init_start);
endmodule // sdram_refresh_asserts
`default_nettype wire

// ===== tb/tb_sdram_control_refresh_timer.sv
// Purpose: Self-checking bench for the SDRAM control and refresh timer.
// Assumes: 25 MHz clock, reset held for eight cycles.
// Notes:   Timer intervals follow the package clock divide.
`timescale 1ns/100ps
`default_nettype none
bind sdram_control_refresh_timer sdram_refresh_asserts u_chk (.clk,
   .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .half_rate_clock_out, .column_width_select, .column_pin_count,
   .row_elements, .timing_fields, .rcd_wait_cycles, .rp_wait_cycles,
   .rc_wait_cycles, .init_start, .bus_request_out, .refresh_done,
   .refresh_event, .dma_sync_event);
module tb_sdram_control_refresh_timer;
   import sdram_ctl_pkg::*;
   logic clk, sys_rst, reg_wr, reg_rd, slow, half_rate_clock_out, irq;
   logic column_width_select, init_start, bus_request_out, refresh_done;
   logic refresh_event, dma_sync_event;
   logic [3:0]    reg_addr, column_pin_count;
   logic [31:0]   reg_wdata, reg_rdata, rd_val;
   logic [9:0]    row_elements;
   logic [4:0]    rcd_wait_cycles, rp_wait_cycles, rc_wait_cycles;
   sdram_timing_t timing_fields;
   int            failures, tests_run;
   sdram_control_refresh_timer u_dut (.clk, .sys_rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .half_rate_clock_out,
      .column_width_select, .column_pin_count, .row_elements,
      .timing_fields, .rcd_wait_cycles, .rp_wait_cycles, .rc_wait_cycles,
      .init_start, .bus_request_out, .refresh_done, .refresh_event,
      .dma_sync_event, .irq);
   sdram_refresh_partner u_far (.clk, .sys_rst, .bus_request_out, .slow,
      .refresh_done);
   // ==========================================================
   // Helpers
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   // Waits on the event (b=0) or the bus request (b=1), never forever.
   task automatic wait_for(input bit b, input logic v, input int n);
      int i;
      i = 0;
      while ((b ? bus_request_out : refresh_event) !== v && i < n) begin
         @(posedge clk);
         #1 i++;
      end
      check("wait outcome", 32'(v), 32'(b ? bus_request_out : refresh_event));
      if (i >= n) final_report();
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd(ADDR_CONTROL);
      check("control rst", 32'h0288f000, rd_val & ~32'h01000000);
      rd(ADDR_TIMING);
      check("timing rst", 32'h00000080, rd_val & 32'hff000fff);
      check("count rst", 1, 32'(rd_val[23:12] >= 12'h07c));
   endtask
   task automatic t_control;
      logic [31:0] w [2] = '{32'hffffffff, 32'h00321000};
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_CONTROL, w[k]);
         rd(ADDR_CONTROL);
         check("control", w[k] & 32'h06fff000, rd_val & ~32'h01000000);
         check("pins", w[k][26] ? 8 : 9, 32'(column_pin_count));
         check("rows", w[k][26] ? 256 : 512, 32'(row_elements));
         check("waits", {17'h0, w[k][23:20] + 5'h1, w[k][19:16] + 5'h1,
            w[k][15:12] + 5'h1}, {17'h0, rcd_wait_cycles, rp_wait_cycles,
            rc_wait_cycles});
      end
      wr(4'h2, 32'hffffffff);
      rd(4'h2);
      check("unmapped", 0, rd_val);
   endtask
   task automatic t_timer;
      int n;
      wr(ADDR_IRQ_MASK, 32'h1);
      wr(ADDR_TIMING, 32'hff000003);
      wait_for(0, 1, 400);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (refresh_event !== 1'b1 && n < 40);
      check("interval", 4 * CLK_DIV, n);
      @(posedge clk);
      #1 check("irq set", 1, 32'(irq));
      rd(ADDR_IRQ_STAT);
      check("status", 1, rd_val & 32'h1);
      rd(ADDR_IRQ_STAT);
      check("status clr", 0, rd_val & 32'h1);
      check("irq clr", 0, 32'(irq));
      rd(ADDR_TIMING);
      check("timing", 32'h3, rd_val & 32'hff000fff);
      check("count", 1, 32'(rd_val[23:12] <= 12'h003));
      wr(ADDR_IRQ_MASK, 32'h0);
      wait_for(0, 1, 20);
      repeat (2) @(posedge clk);
      #1 check("irq masked", 0, 32'(irq));
      check("no request", 0, 32'(bus_request_out));
   endtask
   task automatic t_refresh;
      int n;
      wr(ADDR_TIMING, 32'h1f);
      wr(ADDR_CONTROL, 32'h02321000);
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         wait_for(1, 1, 200);
         wait_for(1, 0, 20);
      end
      wr(ADDR_CONTROL, 32'h00321000);
      n = 0;
      repeat (160) begin
         @(posedge clk);
         #1 n += int'(bus_request_out !== 1'b0);
      end
      check("disabled request", 0, n);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      sys_rst   = 1'b1;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 4'h0;
      reg_wdata = 32'h0;
      slow      = 1'b0;
      failures  = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_control();
      t_timer();
      t_refresh();
      final_report();
   end
endmodule // tb_sdram_control_refresh_timer
`default_nettype wire
